/* design/sbfwc_pkg.sv */
// constants shared by the sample buffer flush and watermark control files
// assumes an 8-bit register port and an external sample store behind the fifo
package sbfwc_pkg;
   // register map
   localparam logic [7:0] REG_ADDR_CFG2 = 8'h27;
   localparam logic [7:0] REG_RESET_CFG2 = 8'h00;
   localparam int FLUSH_BIT = 7;
   localparam int KEEP_BIT = 6;
   localparam int WMRK_LSB = 0;
   localparam int WMRK_W = 6;
   // buffer mode field of queue_setup_one, supplied from outside
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_STREAM = 2'h1;
   localparam logic [1:0] MODE_STOP = 2'h2;
   localparam logic [1:0] MODE_TRIG = 2'h3;
   // storage sizing
   localparam int CNT_W = 6;
   localparam logic [5:0] CAPACITY = 6'h20;
   localparam int SAMPLE_W = 36;
   localparam int FIFO_DEPTH = 8;
endpackage

/* design/sbfwc_fifo.sv */
// small synchronous fifo with valid/ready on both sides and a flush
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module sbfwc_fifo #(
   parameter int W = 36,
   parameter int DEPTH = 8
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic flush_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [W-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [W-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } sbfwc_fifo_s;
   sbfwc_fifo_s s_q;
   sbfwc_fifo_s s_d;
   logic full;
   logic empty;
   logic push;
   logic pop;

   assign empty = (s_q.wp == s_q.rp);
   assign full = (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]) && (s_q.wp[AW] != s_q.rp[AW]);
   assign in_ready_out = !full;
   assign out_valid_out = !empty;
   assign out_data_out = s_q.mem[s_q.rp[AW-1:0]];
   assign push = in_valid_in && !full;
   assign pop = out_ready_in && !empty;

   always_comb begin
      s_d = s_q;
      if (flush_in) begin
         s_d.wp = '0;
         s_d.rp = '0;
      end else begin
         if (push) begin
            s_d.mem[s_q.wp[AW-1:0]] = in_data_in;
            s_d.wp = s_q.wp + 1'b1;
         end
         if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

/* design/sbfwc_ctrl.sv */
// sample buffer flush, keep-awake and watermark control
// assumes the serial interface turns host accesses into one-cycle strobes
// and an external store takes samples over store_valid/store_ready
//
// Notes on behaviour
// - purge discards samples, clears flags and count
// - purge also clears power state gate fields
// - purge bit self-clears, always reads zero
// - keep-awake zero ignores buffer flags
// - keep-awake one lets flags hold wake
// - flags still set at timeout mean sleep
// - clearing flags restarts idle timer
// - keep-awake only acts in stream or stop
// - watermark flag when count reaches threshold
// - threshold zero never raises watermark flag
// - triggered mode keeps threshold pre-trigger samples
// - disabled mode purges like the purge bit
// - after trigger collect remainder, overflow, stop
`timescale 1ns/1ps
module sbfwc_ctrl (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   input wire logic [1:0] buf_mode_in,
   input wire logic trigger_in,
   input wire logic sample_valid_in,
   output logic sample_ready_out,
   input wire logic [sbfwc_pkg::SAMPLE_W-1:0] sample_data_in,
   output logic store_valid_out,
   input wire logic store_ready_in,
   output logic [sbfwc_pkg::SAMPLE_W-1:0] store_data_out,
   output logic store_drop_oldest_out,
   output logic store_purge_out,
   input wire logic host_read_in,
   input wire logic idle_timer_expired_in,
   output logic idle_timer_restart_out,
   output logic sleep_request_out,
   output logic queue_keeps_awake_out,
   output logic gate_clear_out,
   output logic queue_overflow_flag_out,
   output logic watermark_flag_out,
   output logic [sbfwc_pkg::CNT_W-1:0] sample_count_out
);
   typedef struct packed {
      logic [1:0] trig_sync;
      logic keep;
      logic [5:0] wmrk;
      logic flush;
      logic [5:0] count;
      logic ovf;
      logic wm;
      logic trig_seen;
      logic [5:0] post;
      logic restart;
      logic gate_clr;
      logic [7:0] rdata;
   } sbfwc_ctrl_s;
   sbfwc_ctrl_s s_q;
   sbfwc_ctrl_s s_d;

   logic wr_hit;
   logic rd_hit;
   logic mode_off;
   logic mode_trig;
   logic purge;
   logic halted;
   logic accept;
   logic overwrite;
   logic stop_full;
   logic pre_block;
   logic trig_done;
   logic emptied;
   logic read_ok;
   logic fifo_valid;
   logic [5:0] post_goal;

   ////////////////////////////////////////////////////////////////////////////////////
   // staging fifo between sensor and sample store
   sbfwc_fifo #(
      .W(sbfwc_pkg::SAMPLE_W),
      .DEPTH(sbfwc_pkg::FIFO_DEPTH)
   ) sbfwc_fifo_inst (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .flush_in(purge),
      .in_valid_in(sample_valid_in),
      .in_ready_out(sample_ready_out),
      .in_data_in(sample_data_in),
      .out_valid_out(fifo_valid),
      .out_ready_in(store_ready_in && !halted),
      .out_data_out(store_data_out)
   );

   ////////////////////////////////////////////////////////////////////////////////////
   // decode and buffer conditions
   assign wr_hit = reg_wr_in && (reg_addr_in == sbfwc_pkg::REG_ADDR_CFG2);
   assign rd_hit = reg_rd_in && (reg_addr_in == sbfwc_pkg::REG_ADDR_CFG2);
   assign mode_off = (buf_mode_in == sbfwc_pkg::MODE_OFF);
   assign mode_trig = (buf_mode_in == sbfwc_pkg::MODE_TRIG);
   assign purge = s_q.flush || mode_off;
   assign post_goal = sbfwc_pkg::CAPACITY - s_q.wmrk;
   assign stop_full = (buf_mode_in == sbfwc_pkg::MODE_STOP) && (s_q.count == sbfwc_pkg::CAPACITY);
   // zero pre-trigger samples allowed: hold samples back until the trigger
   assign pre_block = mode_trig && !s_q.trig_seen && (s_q.wmrk == 6'h00);
   assign trig_done = mode_trig && s_q.trig_seen && (s_q.post >= post_goal);
   assign halted = purge || stop_full || pre_block || trig_done;
   assign store_valid_out = fifo_valid && !halted;
   assign accept = store_valid_out && store_ready_in;
   // stream wraps when full; triggered mode keeps only the newest pre-trigger samples
   assign overwrite = ((buf_mode_in == sbfwc_pkg::MODE_STREAM)
      && (s_q.count == sbfwc_pkg::CAPACITY))
      || (mode_trig && !s_q.trig_seen && (s_q.count >= s_q.wmrk));
   assign store_drop_oldest_out = accept && overwrite;
   assign store_purge_out = purge;
   assign read_ok = host_read_in && (s_q.count != 6'h00) && !purge;
   assign emptied = read_ok && (s_q.count == 6'h01);

   ////////////////////////////////////////////////////////////////////////////////////
   // wake/sleep interaction
   assign queue_keeps_awake_out = s_q.keep && (s_q.wm || s_q.ovf)
      && ((buf_mode_in == sbfwc_pkg::MODE_STREAM)
      || (buf_mode_in == sbfwc_pkg::MODE_STOP));
   assign sleep_request_out = queue_keeps_awake_out && idle_timer_expired_in;
   assign idle_timer_restart_out = s_q.restart;
   assign gate_clear_out = s_q.gate_clr;
   assign queue_overflow_flag_out = s_q.ovf;
   assign watermark_flag_out = s_q.wm;
   assign sample_count_out = s_q.count;
   assign reg_rdata_out = s_q.rdata;

   always_comb begin
      s_d = s_q;
      s_d.trig_sync = {s_q.trig_sync[0], trigger_in};
      s_d.flush = wr_hit && reg_wdata_in[sbfwc_pkg::FLUSH_BIT];
      if (wr_hit) begin
         s_d.keep = reg_wdata_in[sbfwc_pkg::KEEP_BIT];
         s_d.wmrk = reg_wdata_in[sbfwc_pkg::WMRK_LSB +: sbfwc_pkg::WMRK_W];
      end
      // flush bit is held for one cycle only and never read back, so it reads as zero
      s_d.rdata = rd_hit ? {1'b0, s_q.keep, s_q.wmrk} : 8'h00;
      if (purge) begin
         s_d.count = 6'h00;
         s_d.ovf = 1'b0;
         s_d.trig_seen = 1'b0;
         s_d.post = 6'h00;
      end else begin
         if (accept && !overwrite && !read_ok) begin
            s_d.count = s_q.count + 6'h01;
         end else if (read_ok && !(accept && !overwrite)) begin
            s_d.count = s_q.count - 6'h01;
         end
         if (emptied) begin
            s_d.trig_seen = 1'b0;
            s_d.post = 6'h00;
         end else if (mode_trig && !s_q.trig_seen && s_q.trig_sync[1]) begin
            s_d.trig_seen = 1'b1;
         end else if (s_q.trig_seen && accept) begin
            s_d.post = s_q.post + 6'h01;
         end
         // a set in the same cycle as a host read wins over the clear
         if ((accept && overwrite && !mode_trig) || (stop_full && fifo_valid)
               || (s_q.trig_seen && accept && (s_q.post + 6'h01 >= post_goal))) begin
            s_d.ovf = 1'b1;
         end else if (read_ok) begin
            s_d.ovf = 1'b0;
         end
      end
      s_d.wm = (s_d.wmrk != 6'h00) && (s_d.count >= s_d.wmrk);
      s_d.restart = (s_q.wm || s_q.ovf) && (purge || read_ok) && !(s_d.wm || s_d.ovf);
      s_d.gate_clr = purge || emptied;
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s_q <= '0;
         s_q.keep <= sbfwc_pkg::REG_RESET_CFG2[sbfwc_pkg::KEEP_BIT];
         s_q.wmrk <= sbfwc_pkg::REG_RESET_CFG2[sbfwc_pkg::WMRK_LSB +: sbfwc_pkg::WMRK_W];
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   chk_flush_self_clear: assert property (
      wr_hit && reg_wdata_in[sbfwc_pkg::FLUSH_BIT] |=> s_q.flush
      ##1 (!s_q.flush || $past(wr_hit && reg_wdata_in[sbfwc_pkg::FLUSH_BIT])))
      else $error("flush bit did not self clear");
   chk_flush_reads_zero: assert property (
      rd_hit |=> !reg_rdata_out[sbfwc_pkg::FLUSH_BIT])
      else $error("flush bit read as one");
   chk_purge_clears_all: assert property (
      purge |=> sample_count_out == 6'h00 && !queue_overflow_flag_out && !watermark_flag_out)
      else $error("purge left samples or flags");
   chk_purge_gate_clear: assert property (
      purge |=> gate_clear_out)
      else $error("purge did not clear gate fields");
   chk_disable_purges: assert property (
      mode_off |-> store_purge_out ##1 sample_count_out == 6'h00)
      else $error("disabled mode did not purge");
   chk_keep_off_ignored: assert property (
      !s_q.keep |-> !queue_keeps_awake_out && !sleep_request_out)
      else $error("flags used with keep-awake clear");
   chk_keep_mode_gate: assert property (
      buf_mode_in != sbfwc_pkg::MODE_STREAM && buf_mode_in != sbfwc_pkg::MODE_STOP
      |-> !queue_keeps_awake_out)
      else $error("keep-awake active in wrong mode");
   chk_sleep_on_timeout: assert property (
      s_q.keep && buf_mode_in == sbfwc_pkg::MODE_STREAM && s_q.wm && idle_timer_expired_in
      |-> sleep_request_out)
      else $error("no sleep with flags set at timeout");
   chk_restart_on_clear: assert property (
      (s_q.wm || s_q.ovf) && read_ok |=> !(s_q.wm || s_q.ovf) |-> idle_timer_restart_out)
      else $error("idle timer not restarted");
   chk_wmrk_zero_quiet: assert property (
      s_q.wmrk == 6'h00 |-> !watermark_flag_out)
      else $error("watermark flag with zero threshold");
   chk_wmrk_reached: assert property (
      $stable(s_q.wmrk) && s_q.wmrk != 6'h00 && sample_count_out >= s_q.wmrk
      |-> watermark_flag_out)
      else $error("watermark flag missing");
   chk_post_trig_stop: assert property (
      trig_done && !read_ok && !purge |-> !store_valid_out
      ##1 sample_count_out == $past(sample_count_out))
      else $error("collection continued after trigger quota");
   chk_purge_keeps_fields: assert property (
      wr_hit && reg_wdata_in[sbfwc_pkg::FLUSH_BIT] |=> s_q.wmrk == $past(reg_wdata_in[5:0]))
      else $error("purge write lost threshold");
endmodule

/* dv/sbfwc_store_model.sv */
// partner model: external sample store that takes samples from the control block
// assumes one clock and a synchronous active-high reset; slow_in stalls every other cycle
`timescale 1ns/1ps
module sbfwc_store_model (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic slow_in,
   input wire logic store_valid_in,
   output logic store_ready_out
);
   logic phase_q;
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         phase_q <= 1'b0;
      end else begin
         phase_q <= ~phase_q;
      end
   end
   // a slow store only takes a sample on alternate cycles
   assign store_ready_out = slow_in ? phase_q : 1'b1;
endmodule

/* dv/sbfwc_ctrl_tb_top.sv */
// self-checking bench for the sample buffer flush and watermark control
// assumes the store model as far side; inputs change on the falling clock edge
`timescale 1ns/1ps
`define CHK(a, e) begin \
   num_checks++; \
   if ((a) !== (e)) begin \
      n_mismatch++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); \
   end \
end
module sbfwc_ctrl_tb_top;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [1:0] mode = sbfwc_pkg::MODE_STREAM;
   logic trig = 1'b0;
   logic s_valid = 1'b0;
   logic [35:0] s_data = 36'h0;
   logic host_rd = 1'b0;
   logic expired = 1'b0;
   logic slow = 1'b0;
   logic [7:0] rdata;
   logic s_ready, st_valid, st_ready, purge, restart, sleep_req, keeps, gate_clr, ovf, wm;
   logic [5:0] cnt;
   logic seen_restart, seen_gate;
   logic st_drop;
   logic [35:0] st_data;
   logic [35:0] last_data = 36'h0;
   int n_drop = 0;
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc = 0;
   always #12.5 clk_in = ~clk_in;
   sbfwc_ctrl sbfwc_ctrl_inst (.clk_in(clk_in), .reset_in(reset_in), .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .buf_mode_in(mode), .trigger_in(trig), .sample_valid_in(s_valid),
      .sample_ready_out(s_ready), .sample_data_in(s_data), .store_valid_out(st_valid),
      .store_ready_in(st_ready), .store_data_out(st_data), .store_drop_oldest_out(st_drop),
      .store_purge_out(purge), .host_read_in(host_rd), .idle_timer_expired_in(expired),
      .idle_timer_restart_out(restart), .sleep_request_out(sleep_req),
      .queue_keeps_awake_out(keeps), .gate_clear_out(gate_clr),
      .queue_overflow_flag_out(ovf), .watermark_flag_out(wm), .sample_count_out(cnt));
   sbfwc_store_model sbfwc_store_model_inst (.clk_in(clk_in), .reset_in(reset_in),
      .slow_in(slow), .store_valid_in(st_valid), .store_ready_out(st_ready));
   // notes every sample the store takes: its data and whether the oldest was dropped
   always @(posedge clk_in) begin
      if (!reset_in && st_valid && st_ready) begin
         last_data <= st_data;
         if (st_drop) begin
            n_drop <= n_drop + 1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         final_report();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      reg_wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk_in);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk_in);
      reg_rd = 1'b1;
      addr = a;
      @(negedge clk_in);
      reg_rd = 1'b0;
      v = rdata;
   endtask
   task automatic push(input int n);
      int w;
      for (int i = 0; i < n; i++) begin
         @(negedge clk_in);
         s_valid = 1'b1;
         s_data = 36'(i + 1);
         w = 0;
         while (!s_ready && w < 100) begin
            @(negedge clk_in);
            w++;
         end
      end
      @(negedge clk_in);
      s_valid = 1'b0;
   endtask
   // waits for the store to stop taking samples, noting one-cycle pulses meanwhile
   task automatic settle();
      int k;
      k = 0;
      seen_restart = 1'b0;
      seen_gate = 1'b0;
      while ((st_valid || k < 4) && k < 200) begin
         @(negedge clk_in);
         host_rd = 1'b0;
         seen_restart = seen_restart | restart;
         seen_gate = seen_gate | gate_clr;
         k++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [7:0] v;
      rd(8'h27, v);
      `CHK(v, sbfwc_pkg::REG_RESET_CFG2)
      `CHK({cnt, wm, ovf, s_ready}, 9'h001)
   endtask
   task automatic t_stream();
      logic [7:0] v;
      wr(8'h27, 8'h43);
      rd(8'h27, v);
      `CHK(v, 8'h43)
      rd(8'h28, v);
      `CHK(v, 8'h00)
      slow = 1'b1;
      push(2);
      settle();
      `CHK({cnt, wm, keeps}, 8'h08)
      push(1);
      settle();
      `CHK({cnt, wm, keeps}, 8'h0F)
      expired = 1'b1;
      @(negedge clk_in);
      `CHK(sleep_req, 1'b1)
      expired = 1'b0;
      mode = sbfwc_pkg::MODE_TRIG;
      @(negedge clk_in);
      `CHK(keeps, 1'b0)
      mode = sbfwc_pkg::MODE_STREAM;
      @(negedge clk_in);
      host_rd = 1'b1;
      settle();
      `CHK({cnt, wm, seen_restart}, 8'h09)
      slow = 1'b0;
   endtask
   task automatic t_purge();
      logic [7:0] v;
      wr(8'h27, 8'hC2);
      settle();
      `CHK({cnt, wm, ovf}, 8'h00)
      `CHK({seen_gate, seen_restart}, 2'h3)
      rd(8'h27, v);
      `CHK(v, 8'h42)
      wr(8'h27, 8'h01);
      push(1);
      settle();
      `CHK({wm, keeps}, 2'h2)
      host_rd = 1'b1;
      settle();
      `CHK({cnt, wm, seen_gate}, 8'h01)
      wr(8'h27, 8'h00);
      push(4);
      settle();
      `CHK({cnt, wm}, 7'h08)
   endtask
   task automatic t_stop();
      wr(8'h27, 8'h40);
      mode = sbfwc_pkg::MODE_STOP;
      push(33);
      settle();
      `CHK({cnt, ovf, keeps}, 8'h83)
      mode = sbfwc_pkg::MODE_OFF;
      repeat (3) @(negedge clk_in);
      `CHK({purge, cnt, ovf}, 8'h80)
   endtask
   task automatic t_trig();
      wr(8'h27, 8'h44);
      mode = sbfwc_pkg::MODE_TRIG;
      push(6);
      settle();
      `CHK({cnt, wm, keeps}, 8'h12)
      `CHK(n_drop, 2)
      trig = 1'b1;
      repeat (4) @(negedge clk_in);
      trig = 1'b0;
      push(36);
      settle();
      `CHK({cnt, ovf, keeps}, 8'h82)
      `CHK(last_data, 36'h1C)
   endtask
   initial begin
      repeat (16) @(negedge clk_in);
      reset_in = 1'b0;
      t_reset();
      t_stream();
      t_purge();
      t_stop();
      t_trig();
      final_report();
   end
endmodule
